// *** rtl/clkcfg_pkg.sv ***
// package for the four-channel clock output configuration block
// assumes a single 50 MHz clock domain and a plain register port
`default_nettype none
package clkcfg_pkg;
    // register offsets (byte addresses, one word each)
    localparam logic [7:0] SOFT_RESET_CONTROL_OFF         = 8'h00;
    localparam logic [7:0] CHANNEL0_OUTPUT_CONFIG_OFF     = 8'h10;
    localparam logic [7:0] CHANNEL1_OUTPUT_CONFIG_OFF     = 8'h14;
    localparam logic [7:0] CHANNEL2_OUTPUT_CONFIG_OFF     = 8'h18;
    localparam logic [7:0] CHANNEL3_OUTPUT_CONFIG_OFF     = 8'h1c;
    localparam logic [7:0] LOCK_DETECT_PRESCALE_OFF       = 8'h2c;
    localparam logic [7:0] PLL_REFERENCE_AND_GLOBAL_OFF   = 8'h38;
    localparam logic [7:0] PLL_FEEDBACK_AND_PUMP_GAIN_OFF = 8'h3c;
    localparam logic [7:0] CHANNEL_STATUS_OFF             = 8'h40;

    // field positions
    localparam int SOFT_RESET_POS   = 31;
    localparam int PATH_SEL_POS     = 17;
    localparam int CH_EN_POS        = 16;
    localparam int DIV_POS          = 8;
    localparam int DLY_POS          = 4;
    localparam int PRESCALE_POS     = 15;
    localparam int GLOBAL_EN_POS    = 27;
    localparam int SLEEP_POS        = 26;
    localparam int FLOAT_POS        = 25;
    localparam int POLARITY_POS     = 24;
    localparam int LD_MUX_POS       = 20;
    localparam int REF_DIV_POS      = 8;
    localparam int PUMP_GAIN_POS    = 30;
    localparam int FB_DIV_POS       = 8;

    // reset values
    localparam logic [7:0]  DIV_RESET     = 8'h01;
    localparam logic [3:0]  DLY_RESET     = 4'h0;
    localparam logic [11:0] REF_DIV_RESET = 12'h00a;
    localparam logic [17:0] FB_DIV_RESET  = 18'h002f8;
    localparam logic        GLOBAL_EN_RESET = 1'b1;

    // delay step size in ps
    localparam logic [11:0] DELAY_STEP_PS = 12'h096;
    localparam logic [2:0]  PRESCALE_RATIO = 3'h4;

    typedef enum logic [1:0] {
        PATH_BYPASS  = 2'h0,
        PATH_DIVIDED = 2'h1,
        PATH_DELAYED = 2'h2,
        PATH_DIV_DLY = 2'h3
    } path_sel_t;

    typedef struct packed {
        path_sel_t  path;
        logic       enable;
        logic [7:0] div_code;
        logic [3:0] dly_code;
    } channel_cfg_t;

    typedef struct packed {
        logic        active;
        logic        div_used;
        logic [8:0]  div_ratio;
        logic        dly_used;
        logic [11:0] dly_ps;
    } channel_eff_t;

    typedef struct packed {
        logic        global_en;
        logic        sleep;
        logic        pump_float;
        logic        pump_pol;
        logic [3:0]  ld_mux;
        logic [11:0] ref_div;
        logic [1:0]  pump_gain;
        logic [17:0] fb_div;
        logic        ld_prescale;
    } pll_cfg_t;

    // divide ratio of a channel: twice the code
    function automatic logic [8:0] div_ratio(input logic [7:0] code);
        return {code, 1'b0};
    endfunction

    // delay in ps for a code
    function automatic logic [11:0] dly_ps(input logic [3:0] code);
        logic [15:0] p;
        p = 16'(code) * 16'(DELAY_STEP_PS);
        return p[11:0];
    endfunction
endpackage
`default_nettype wire

// *** rtl/channel_shaper.sv ***
// one channel's effective settings from its config and global gating
// assumes synchronous inputs on mclk
`default_nettype none
module channel_shaper (
    input  wire logic                    mclk,
    input  wire logic                    rst_n,
    input  wire clkcfg_pkg::channel_cfg_t cfg,
    input  wire logic                    gate_on,
    input  wire logic [2:0]              prescale,
    output var  clkcfg_pkg::channel_eff_t eff,
    output logic [11:0]                  total_div
);
    import clkcfg_pkg::*;

    channel_eff_t eff_d;
    logic [11:0]  total_d;

    // ----------------------------------------
    // effective path settings
    // ----------------------------------------
    always_comb begin
        eff_d = '0;
        eff_d.active    = cfg.enable & gate_on;
        eff_d.div_used  = (cfg.path == PATH_DIVIDED) || (cfg.path == PATH_DIV_DLY);
        eff_d.dly_used  = (cfg.path == PATH_DELAYED) || (cfg.path == PATH_DIV_DLY);
        eff_d.div_ratio = eff_d.div_used ? div_ratio(cfg.div_code) : 9'h001;
        eff_d.dly_ps    = eff_d.dly_used ? dly_ps(cfg.dly_code) : 12'h000;
        total_d         = 12'(eff_d.div_ratio) * 12'(prescale);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            eff       <= '0;
            total_div <= '0;
        end else begin
            eff       <= eff_d;
            total_div <= total_d;
        end
    end
endmodule
`default_nettype wire

// *** rtl/clkcfg_top.sv ***
// register file and output gating for the clock output configuration
// assumes a one-cycle register port master and a synchronous enable pin
`default_nettype none
//Contract
// - writing one to bit 31 of the soft reset register restores every register default.
// - a write with the reset bit set ignores all other fields of that register.
// - path code 0 bypass, 1 divided, 2 delayed, 3 divided then delayed, bypass by default.
// - the divider only matters in divided or divided-delayed modes.
// - divide ratio is twice the eight-bit code, code one by default.
// - overall division is prescaler ratio times the channel ratio.
// - the delay code only matters in delayed or divided-delayed modes.
// - delay is 150 ps per code step, zero by default.
// - an output is active only with its enable, the global bit and the pin high.
// - the prescale bit divides the lock detector rate by four.
// - the twelve-bit reference divider divides by its value, default 10.
// - clearing the global enable bit turns all outputs off, default one.
// - the eighteen-bit feedback divider divides by its value, default 760.
module clkcfg_top (
    input  wire logic                     mclk,
    input  wire logic                     arst_n,
    input  wire logic [7:0]               addr,
    input  wire logic [31:0]              wdata,
    input  wire logic                     wr_stb,
    input  wire logic                     rd_stb,
    input  wire logic                     global_enable_pin,
    input  wire logic [2:0]               vco_prescale,
    output logic [31:0]                   rdata,
    output logic [3:0]                    channel_active,
    output var  clkcfg_pkg::pll_cfg_t     pll_cfg,
    output logic [11:0]                   ref_div_value,
    output logic [17:0]                   fb_div_value,
    output logic                          ld_rate_lock_detect_prescale_bit,
    output logic [47:0]                   channel_total_div
);
    import clkcfg_pkg::*;

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ----------------------------------------
    // register state
    // ----------------------------------------
    channel_cfg_t ch_q [4];
    channel_cfg_t ch_d [4];
    pll_cfg_t     pll_q;
    pll_cfg_t     pll_d;
    logic [31:0]  rdata_d;
    logic         soft_rst;

    localparam channel_cfg_t CH_RESET = '{path: PATH_BYPASS, enable: 1'b0, div_code: DIV_RESET,
                                          dly_code: DLY_RESET};
    localparam pll_cfg_t PLL_RESET = '{global_en: GLOBAL_EN_RESET, sleep: 1'b0, pump_float: 1'b0,
                                       pump_pol: 1'b0, ld_mux: 4'h0, ref_div: REF_DIV_RESET,
                                       pump_gain: 2'h0, fb_div: FB_DIV_RESET, ld_prescale: 1'b0};

    // write decode and soft reset
    always_comb begin
        soft_rst = wr_stb && (addr == SOFT_RESET_CONTROL_OFF) && wdata[SOFT_RESET_POS];
        for (int i = 0; i < 4; i++) begin
            ch_d[i] = ch_q[i];
        end
        pll_d = pll_q;
        if (soft_rst) begin
            // all defaults, other fields of the write dropped
            for (int i = 0; i < 4; i++) begin
                ch_d[i] = CH_RESET;
            end
            pll_d = PLL_RESET;
        end else if (wr_stb) begin
            for (int i = 0; i < 4; i++) begin
                if (addr == CHANNEL0_OUTPUT_CONFIG_OFF + 8'(4 * i)) begin
                    ch_d[i].path     = path_sel_t'(wdata[PATH_SEL_POS +: 2]);
                    ch_d[i].enable   = wdata[CH_EN_POS];
                    ch_d[i].div_code = wdata[DIV_POS +: 8];
                    ch_d[i].dly_code = wdata[DLY_POS +: 4];
                end
            end
            if (addr == LOCK_DETECT_PRESCALE_OFF) begin
                pll_d.ld_prescale = wdata[PRESCALE_POS];
            end
            if (addr == PLL_REFERENCE_AND_GLOBAL_OFF) begin
                pll_d.global_en  = wdata[GLOBAL_EN_POS];
                pll_d.sleep      = wdata[SLEEP_POS];
                pll_d.pump_float = wdata[FLOAT_POS];
                pll_d.pump_pol   = wdata[POLARITY_POS];
                pll_d.ld_mux     = wdata[LD_MUX_POS +: 4];
                pll_d.ref_div    = wdata[REF_DIV_POS +: 12];
            end
            if (addr == PLL_FEEDBACK_AND_PUMP_GAIN_OFF) begin
                pll_d.pump_gain = wdata[PUMP_GAIN_POS +: 2];
                pll_d.fb_div    = wdata[FB_DIV_POS +: 18];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                ch_q[i] <= CH_RESET;
            end
            pll_q <= PLL_RESET;
        end else begin
            for (int i = 0; i < 4; i++) begin
                ch_q[i] <= ch_d[i];
            end
            pll_q <= pll_d;
        end
    end

    // ----------------------------------------
    // channel shaping
    // ----------------------------------------
    logic         gate_on;
    channel_eff_t eff [4];
    logic [11:0]  tot [4];

    assign gate_on = pll_q.global_en & global_enable_pin;

    for (genvar g = 0; g < 4; g++) begin : g_ch
        channel_shaper u_shaper (
            .mclk      (mclk),
            .rst_n     (rst_n),
            .cfg       (ch_q[g]),
            .gate_on   (gate_on),
            .prescale  (vco_prescale),
            .eff       (eff[g]),
            .total_div (tot[g])
        );
    end

    // ----------------------------------------
    // readback and outputs
    // ----------------------------------------
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (rd_stb) begin
            unique case (addr)
                CHANNEL_STATUS_OFF: begin
                    rdata_d = {28'h0000000, eff[3].active, eff[2].active, eff[1].active, eff[0].active};
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata             <= '0;
            channel_active    <= '0;
            pll_cfg           <= PLL_RESET;
            ref_div_value     <= REF_DIV_RESET;
            fb_div_value      <= FB_DIV_RESET;
            ld_rate_lock_detect_prescale_bit      <= 1'b0;
            channel_total_div <= '0;
        end else begin
            rdata             <= rdata_d;
            channel_active    <= {eff[3].active, eff[2].active, eff[1].active, eff[0].active};
            pll_cfg           <= pll_q;
            ref_div_value     <= pll_q.ref_div;
            fb_div_value      <= pll_q.fb_div;
            ld_rate_lock_detect_prescale_bit      <= pll_q.ld_prescale;
            channel_total_div <= {tot[3], tot[2], tot[1], tot[0]};
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // soft reset restores the pll defaults
    soft_reset_defaults_a: assert property (@(posedge mclk) disable iff (!rst_n)
        soft_rst |=> (pll_q.ref_div == REF_DIV_RESET && pll_q.fb_div == FB_DIV_RESET && pll_q.global_en))
        else $error("soft reset did not restore defaults");

    // reset write drops the other fields
    reset_ignores_fields_a: assert property (@(posedge mclk) disable iff (!rst_n)
        soft_rst |=> ch_q[0] == CH_RESET)
        else $error("fields taken during soft reset");

    // soft reset also clears channel and prescale state
    soft_reset_ch_a: assert property (@(posedge mclk) disable iff (!rst_n)
        soft_rst |=> (ch_q[3] == CH_RESET && !pll_q.ld_prescale))
        else $error("soft reset left channel state");

    // global bit off forces all outputs off
    global_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !pll_q.global_en |=> ##1 channel_active == 4'h0)
        else $error("outputs on with global enable cleared");

    // global bit taken from the reference register
    global_take_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_stb && !soft_rst && addr == PLL_REFERENCE_AND_GLOBAL_OFF |=> ##1
        pll_cfg.global_en == $past(wdata[GLOBAL_EN_POS], 2))
        else $error("global enable bit not taken");

    // pin low forces all outputs off
    pin_low_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !global_enable_pin |=> ##1 channel_active == 4'h0)
        else $error("outputs on with enable pin low");

    // each enabled channel comes on when gated on
    ch0_active_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ch_q[0].enable && gate_on) |=> ##1 channel_active[0])
        else $error("channel 0 not active when enabled");

    // channel 1 enable path
    ch1_active_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ch_q[1].enable && gate_on) |=> ##1 channel_active[1])
        else $error("channel 1 not active when enabled");

    // channel 2 enable path
    ch2_active_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ch_q[2].enable && gate_on) |=> ##1 channel_active[2])
        else $error("channel 2 not active when enabled");

    // channel 3 enable path
    ch3_active_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ch_q[3].enable && gate_on) |=> ##1 channel_active[3])
        else $error("channel 3 not active when enabled");

    // own enable cleared keeps channel 0 off
    ch0_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !ch_q[0].enable |=> ##1 !channel_active[0])
        else $error("channel 0 active while disabled");

    // own enable cleared keeps channel 3 off
    ch3_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !ch_q[3].enable |=> ##1 !channel_active[3])
        else $error("channel 3 active while disabled");

    // bypass keeps both blocks out of the path
    bypass_plain_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ch_q[3].path == PATH_BYPASS) |=> (!eff[3].div_used && !eff[3].dly_used))
        else $error("bypass path not plain");

    // divider ignored in bypass
    div_ignored_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ch_q[1].path == PATH_BYPASS) |=> eff[1].div_ratio == 9'h001)
        else $error("divider used in bypass");

    // divider used in divided and delayed mode
    div_dly_used_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ch_q[0].path == PATH_DIV_DLY) |=> (eff[0].div_used && eff[0].dly_used))
        else $error("divider or delay missing in combined mode");

    // ratio is twice the code
    div_ratio_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ch_q[1].path == PATH_DIVIDED) |=> eff[1].div_ratio == {$past(ch_q[1].div_code), 1'b0})
        else $error("divide ratio not twice the code");

    // delay value in delayed mode
    dly_value_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ch_q[2].path == PATH_DELAYED) |=> eff[2].dly_ps == dly_ps($past(ch_q[2].dly_code)))
        else $error("delay value wrong");

    // delay steps of 150 ps in combined mode
    dly_path_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ch_q[3].path == PATH_DIV_DLY) |=> eff[3].dly_ps == {8'h00, $past(ch_q[3].dly_code)} * 12'h096)
        else $error("delay not applied in combined mode");

    // delay ignored in divided mode
    dly_ignored_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ch_q[2].path == PATH_DIVIDED) |=> eff[2].dly_ps == 12'h000)
        else $error("delay used in divided mode");

    // total is prescale times channel ratio
    total_div_a: assert property (@(posedge mclk) disable iff (!rst_n)
        tot[0] == 12'(eff[0].div_ratio) * 12'($past(vco_prescale)))
        else $error("total division wrong");

    // prescale bit reaches its output
    ld_prescale_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_stb && !soft_rst && addr == LOCK_DETECT_PRESCALE_OFF |=> ##1
        ld_rate_lock_detect_prescale_bit == $past(wdata[PRESCALE_POS], 2))
        else $error("prescale bit not taken");

    // reference divider reaches its output
    ref_div_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_stb && !soft_rst && addr == PLL_REFERENCE_AND_GLOBAL_OFF |=> ##1
        ref_div_value == $past(wdata[REF_DIV_POS +: 12], 2))
        else $error("reference divider not taken");

    // feedback divider reaches its output
    fb_div_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_stb && !soft_rst && addr == PLL_FEEDBACK_AND_PUMP_GAIN_OFF |=> ##1
        fb_div_value == $past(wdata[FB_DIV_POS +: 18], 2))
        else $error("feedback divider not taken");

    // status read agrees with the active outputs
    status_match_a: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_stb && addr == CHANNEL_STATUS_OFF |=> rdata == {28'h0000000, channel_active})
        else $error("status read differs from outputs");

    // other reads return zero
    unmapped_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_stb && addr != CHANNEL_STATUS_OFF |=> rdata == 32'h0000_0000)
        else $error("write-only or unmapped read not zero");

    // read data stands one cycle only
    idle_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !rd_stb |=> rdata == 32'h0000_0000)
        else $error("read data outside its cycle");
endmodule
`default_nettype wire

// *** testbench/config_host.sv ***
// host controller model that programs the configuration registers
// assumes the one-cycle register port of the block, sampled on rising mclk
`default_nettype none
module config_host
    import clkcfg_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic [31:0] rdata,
    output logic [7:0]       addr,
    output logic [31:0]      wdata,
    output logic             wr_stb,
    output logic             rd_stb
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        addr = 8'h00;
        wdata = 32'h0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    end

    // one-cycle write; leftovers are inverted so nothing stale looks valid
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        addr   <= ~a;
        wdata  <= ~d;
    endtask

    // one-cycle read; data sampled mid-cycle after the strobe
    task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        addr   <= ~a;
        @(negedge mclk);
        d = rdata;
    endtask

    // ordinary write with the reset bit kept clear
    task automatic write_cfg(input logic [7:0] a, input logic [31:0] d);
        write_reg(a, (a == SOFT_RESET_CONTROL_OFF) ? {1'b0, d[30:0]} : d);
    endtask

    // reference divider and global bits, unused bits written as zero
    task automatic program_ref(input logic g, input logic [11:0] r);
        write_cfg(PLL_REFERENCE_AND_GLOBAL_OFF, {4'h0, g, 3'h0, 4'h0, r, 8'h00});
    endtask

    // prescale bit set only for fast phase detector rates
    task automatic program_ld(input int pd_mhz);
        write_cfg(LOCK_DETECT_PRESCALE_OFF, {16'h0, (pd_mhz > 20), 15'h0});
    endtask
endmodule
`default_nettype wire

// *** testbench/clock_output_channel_config_bench.sv ***
// self-checking bench for the clock output configuration block
// assumes the host model drives the register port; 50 MHz mclk
`default_nettype none
module clock_output_channel_config_bench
    import clkcfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [1:0]  ch;
        logic [1:0]  path;
        logic        en;
        logic [7:0]  div;
        logic [3:0]  dly;
        logic        pin;
        logic [2:0]  presc;
        logic [3:0]  act;
        logic [11:0] tot;
    } row_t;

    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic        pin = 1'b1;
    logic [2:0]  presc = 3'h2;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr_stb;
    logic        rd_stb;
    logic [31:0] rdata;
    logic [3:0]  channel_active;
    pll_cfg_t    pll_cfg;
    logic [11:0] ref_div_value;
    logic [17:0] fb_div_value;
    logic        ld_rate_lock_detect_prescale_bit;
    logic [47:0] channel_total_div;
    int          fails = 0;
    int          samples_checked = 0;

    // channel writes beside the outputs they should give
    row_t rows[6] = '{
        '{2'h0, 2'h0, 1'b1, 8'h05, 4'h3, 1'b1, 3'h2, 4'h1, 12'h002},
        '{2'h1, 2'h1, 1'b1, 8'hff, 4'h0, 1'b1, 3'h2, 4'h3, 12'h3fc},
        '{2'h2, 2'h2, 1'b0, 8'h03, 4'hf, 1'b1, 3'h3, 4'h3, 12'h003},
        '{2'h3, 2'h3, 1'b1, 8'h01, 4'h7, 1'b1, 3'h3, 4'hb, 12'h006},
        '{2'h2, 2'h1, 1'b1, 8'h02, 4'h0, 1'b1, 3'h5, 4'hf, 12'h014},
        '{2'h0, 2'h0, 1'b1, 8'h05, 4'h0, 1'b0, 3'h5, 4'h0, 12'h005}
    };

    // -------------------------------------------------
    // clock, design and host
    // -------------------------------------------------
    initial begin
        forever #10 mclk = ~mclk;
    end

    clkcfg_top DUT (
        .mclk              (mclk),
        .arst_n            (arst_n),
        .addr              (addr),
        .wdata             (wdata),
        .wr_stb            (wr_stb),
        .rd_stb            (rd_stb),
        .global_enable_pin (pin),
        .vco_prescale      (presc),
        .rdata             (rdata),
        .channel_active    (channel_active),
        .pll_cfg           (pll_cfg),
        .ref_div_value     (ref_div_value),
        .fb_div_value      (fb_div_value),
        .ld_rate_lock_detect_prescale_bit      (ld_rate_lock_detect_prescale_bit),
        .channel_total_div (channel_total_div)
    );

    config_host host (
        .mclk   (mclk),
        .rdata  (rdata),
        .addr   (addr),
        .wdata  (wdata),
        .wr_stb (wr_stb),
        .rd_stb (rd_stb)
    );

    // -------------------------------------------------
    // helpers
    // -------------------------------------------------
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // let the two-cycle output latency pass, then sample mid-cycle
    task automatic settle;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
    endtask

    // hold reset four cycles, then wait out the release flops
    task automatic do_reset;
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic check_defaults;
        check(channel_active, 4'h0);
        check(ref_div_value, 12'h00a);
        check(fb_div_value, 18'h002f8);
        check(ld_rate_lock_detect_prescale_bit, 1'b0);
        check(pll_cfg.global_en, 1'b1);
    endtask

    // -------------------------------------------------
    // main sequence
    // -------------------------------------------------
    initial begin
        row_t r;
        logic [31:0] rd;
        do_reset();
        check_defaults();
        check(rdata, 32'h0);
        // table of channel settings
        foreach (rows[i]) begin
            r = rows[i];
            @(posedge mclk);
            pin   <= r.pin;
            presc <= r.presc;
            host.write_cfg(CHANNEL0_OUTPUT_CONFIG_OFF + {4'h0, r.ch, 2'h0}, {13'h0, r.path, r.en, r.div, r.dly, 4'h0});
            settle();
            check(channel_active, r.act);
            check(channel_total_div[int'(r.ch)*12 +: 12], r.tot);
        end
        // channel dividers all written; alignment pulse lies outside this block
        // global bit overrides every enable
        @(posedge mclk);
        pin <= 1'b1;
        host.program_ref(1'b0, 12'h123);
        settle();
        check(channel_active, 4'h0);
        check(ref_div_value, 12'h123);
        host.program_ref(1'b1, 12'hfff);
        host.write_cfg(PLL_FEEDBACK_AND_PUMP_GAIN_OFF, {2'h2, 4'h0, 18'h3ffff, 8'h00});
        host.program_ld(25);
        settle();
        check(channel_active, 4'hf);
        check(ref_div_value, 12'hfff);
        check(fb_div_value, 18'h3ffff);
        check(pll_cfg.pump_gain, 2'h2);
        check(ld_rate_lock_detect_prescale_bit, 1'b1);
        // reads: status, write-only, unmapped, one-cycle data
        host.read_reg(CHANNEL_STATUS_OFF, rd);
        check(rd, 32'h0000000f);
        @(negedge mclk);
        check(rdata, 32'h0);
        host.read_reg(CHANNEL1_OUTPUT_CONFIG_OFF, rd);
        check(rd, 32'h0);
        host.read_reg(8'h7c, rd);
        check(rd, 32'h0);
        // write to the reset register without the reset bit
        host.write_cfg(SOFT_RESET_CONTROL_OFF, 32'hffffffff);
        settle();
        check(ref_div_value, 12'hfff);
        // soft reset with other fields set restores all defaults
        host.write_reg(SOFT_RESET_CONTROL_OFF, 32'h8000ffff);
        settle();
        check_defaults();
        check(channel_total_div, {4{12'h005}});
        // asynchronous reset in mid-run
        host.program_ref(1'b0, 12'h055);
        do_reset();
        check_defaults();
        complete_run();
    end

    // watchdog well beyond the expected run length
    initial begin
        repeat (3000) @(posedge mclk);
        fails++;
        complete_run();
    end
endmodule
`default_nettype wire
